// ---- hdl/half_duplex_direction_adapter.sv ----
// half-duplex direction adapter between an rs-232 port and an rs-485 line
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`default_nettype none
module half_duplex_direction_adapter #(
  parameter int TA_115K_CYC = direction_adapter_pkg::TA_115K_CYC,
  parameter int TA_19K_CYC = direction_adapter_pkg::TA_19K_CYC,
  parameter int TA_9K6_CYC = direction_adapter_pkg::TA_9K6_CYC,
  parameter int TA_4K8_CYC = direction_adapter_pkg::TA_4K8_CYC,
  parameter int TA_2K4_CYC = direction_adapter_pkg::TA_2K4_CYC,
  parameter int TA_1K2_CYC = direction_adapter_pkg::TA_1K2_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [direction_adapter_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // rs-232 data pins 2 and 3
  input wire logic pin2_i,
  output logic pin2_o,
  output logic pin2_oe,
  input wire logic pin3_i,
  output logic pin3_o,
  output logic pin3_oe,
  // rs-232 rts
  output logic rts_o,
  output logic rts_oe,
  // rs-485 line
  input wire logic line_i,
  output logic line_o,
  output logic line_oe,
  // framing selection toward the link
  output logic ten_bit_frame
);

  localparam int CW = direction_adapter_pkg::CNT_W;

  // turnaround count for a baud code
  function automatic logic [CW-1:0] turnaround_cycles(input logic [2:0] code);
    logic [CW-1:0] n;
    n = CW'(TA_1K2_CYC);
    unique case (code)
      direction_adapter_pkg::BAUD_115K: n = CW'(TA_115K_CYC);
      direction_adapter_pkg::BAUD_19K: n = CW'(TA_19K_CYC);
      direction_adapter_pkg::BAUD_9K6: n = CW'(TA_9K6_CYC);
      direction_adapter_pkg::BAUD_4K8: n = CW'(TA_4K8_CYC);
      direction_adapter_pkg::BAUD_2K4: n = CW'(TA_2K4_CYC);
      default: n = CW'(TA_1K2_CYC);
    endcase
    return n;
  endfunction : turnaround_cycles

  // a register is selected when the address equals its byte offset
  function automatic logic addr_hits(input logic [direction_adapter_pkg::ADDR_W-1:0] a,
                                     input logic [direction_adapter_pkg::ADDR_W-1:0] off);
    return (a == off);
  endfunction : addr_hits

  // input synchronisers: two flops on every pin before any logic reads it
  logic [1:0] pin2_sync_q;
  logic [1:0] pin2_sync_d;
  logic [1:0] pin3_sync_q;
  logic [1:0] pin3_sync_d;
  logic [1:0] line_sync_q;
  logic [1:0] line_sync_d;

  always_comb begin
    pin2_sync_d = {pin2_sync_q[0], pin2_i};
    pin3_sync_d = {pin3_sync_q[0], pin3_i};
    line_sync_d = {line_sync_q[0], line_i};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin2_sync_q <= 2'h3;
      pin3_sync_q <= 2'h3;
      line_sync_q <= 2'h3;
    end else begin
      pin2_sync_q <= pin2_sync_d;
      pin3_sync_q <= pin3_sync_d;
      line_sync_q <= line_sync_d;
    end
  end

  // control register
  logic [2:0] baud_q;
  logic [2:0] baud_d;
  logic ten_bit_q;
  logic ten_bit_d;
  logic dte_q;
  logic dte_d;
  logic rts_follow_q;
  logic rts_follow_d;
  logic refused_q;
  logic refused_d;

  logic ctrl_hit;
  logic stat_hit;
  logic wr_ctrl;
  logic [2:0] wr_baud;

  assign ctrl_hit = addr_hits(paddr, direction_adapter_pkg::CTRL_OFFSET);
  assign stat_hit = addr_hits(paddr, direction_adapter_pkg::STATUS_OFFSET);
  assign wr_baud = pwdata[direction_adapter_pkg::CTRL_BAUD_LSB +: 3];
  assign wr_ctrl = psel && penable && pready && pwrite && ctrl_hit;

  always_comb begin
    baud_d = baud_q;
    ten_bit_d = ten_bit_q;
    dte_d = dte_q;
    rts_follow_d = rts_follow_q;
    refused_d = refused_q;
    if (wr_ctrl) begin
      ten_bit_d = pwdata[direction_adapter_pkg::CTRL_TEN_BIT];
      dte_d = pwdata[direction_adapter_pkg::CTRL_DTE];
      rts_follow_d = pwdata[direction_adapter_pkg::CTRL_RTS_FOLLOW];
      // refused baud codes leave the rate unchanged
      if (wr_baud > direction_adapter_pkg::BAUD_1K2) begin
        refused_d = 1'b1;
      end else begin
        baud_d = wr_baud;
        refused_d = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      baud_q <= direction_adapter_pkg::CTRL_BAUD_RST;
      ten_bit_q <= direction_adapter_pkg::CTRL_TEN_BIT_RST;
      dte_q <= direction_adapter_pkg::CTRL_DTE_RST;
      rts_follow_q <= direction_adapter_pkg::CTRL_RTS_FOLLOW_RST;
      refused_q <= 1'b0;
    end else begin
      baud_q <= baud_d;
      ten_bit_q <= ten_bit_d;
      dte_q <= dte_d;
      rts_follow_q <= rts_follow_d;
      refused_q <= refused_d;
    end
  end

  // direction control
  direction_adapter_pkg::direction_t dir_q;
  direction_adapter_pkg::direction_t dir_d;
  logic [CW-1:0] idle_cnt_q;
  logic [CW-1:0] idle_cnt_d;
  logic src_prev_q;
  logic src_prev_d;
  logic src_level;

  // rs-232 transmit data enters on pin 2 in dte, on pin 3 in dce
  assign src_level = dte_q ? pin2_sync_q[1] : pin3_sync_q[1];

  // the idle count only runs in transmit direction
  always_comb begin
    dir_d = dir_q;
    idle_cnt_d = idle_cnt_q;
    src_prev_d = src_level;
    unique case (dir_q)
      direction_adapter_pkg::receive_phase: begin
        idle_cnt_d = '0;
        if (!src_level) begin
          dir_d = direction_adapter_pkg::transmit_phase;
        end
      end
      direction_adapter_pkg::transmit_phase: begin
        if (!src_level || (src_level != src_prev_q)) begin
          idle_cnt_d = '0;
        end else if (idle_cnt_q + CW'(1) >= turnaround_cycles(baud_q)) begin
          dir_d = direction_adapter_pkg::receive_phase;
          idle_cnt_d = '0;
        end else begin
          idle_cnt_d = idle_cnt_q + CW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dir_q <= direction_adapter_pkg::receive_phase;
      idle_cnt_q <= '0;
      src_prev_q <= 1'b1;
    end else begin
      dir_q <= dir_d;
      idle_cnt_q <= idle_cnt_d;
      src_prev_q <= src_prev_d;
    end
  end

  // pin drivers
  logic tx_dir;
  logic rs232_out;
  logic line_o_d;
  logic line_oe_d;
  logic pin2_o_d;
  logic pin2_oe_d;
  logic pin3_o_d;
  logic pin3_oe_d;
  logic rts_o_d;
  logic rts_oe_d;

  assign tx_dir = (dir_d == direction_adapter_pkg::transmit_phase);
  // rs-485 data reaches the rs-232 device only in receive direction
  assign rs232_out = tx_dir ? 1'b1 : line_sync_q[1];

  always_comb begin
    // drive the rs-485 line only in transmit direction, entering at once
    line_oe_d = tx_dir;
    line_o_d = tx_dir ? src_level : 1'b1;
    // rs-485 data goes back toward the rs-232 device on the output pin
    pin2_oe_d = !dte_q;
    pin3_oe_d = dte_q;
    pin2_o_d = rs232_out;
    pin3_o_d = rs232_out;
    // in dte, rts asserted while the controller may transmit, i.e. adapter receiving; in dce held low
    rts_oe_d = dte_q;
    if (!dte_q) begin
      rts_o_d = 1'b0;
    end else if (rts_follow_q) begin
      rts_o_d = !tx_dir;
    end else begin
      rts_o_d = 1'b1;
    end
  end

  // every pin output is registered
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      line_o <= 1'b1;
      line_oe <= 1'b0;
      pin2_o <= 1'b1;
      pin2_oe <= 1'b0;
      pin3_o <= 1'b1;
      pin3_oe <= 1'b0;
      rts_o <= 1'b0;
      rts_oe <= 1'b0;
      ten_bit_frame <= 1'b0;
    end else begin
      line_o <= line_o_d;
      line_oe <= line_oe_d;
      pin2_o <= pin2_o_d;
      pin2_oe <= pin2_oe_d;
      pin3_o <= pin3_o_d;
      pin3_oe <= pin3_oe_d;
      rts_o <= rts_o_d;
      rts_oe <= rts_oe_d;
      ten_bit_frame <= ten_bit_q;
    end
  end

  // apb answer
  logic pready_d;
  logic pslverr_d;
  logic [31:0] prdata_d;
  logic mapped;

  assign mapped = ctrl_hit || stat_hit;

  // one wait state: pready rises in the second access cycle and stands one cycle
  always_comb begin
    pready_d = psel && penable && !pready;
    pslverr_d = pready_d && !mapped;
    prdata_d = '0;
    // read data is zero except in the cycle pready stands
    if (pready_d && !pwrite) begin
      if (ctrl_hit) begin
        prdata_d[direction_adapter_pkg::CTRL_BAUD_LSB +: 3] = baud_q;
        prdata_d[direction_adapter_pkg::CTRL_TEN_BIT] = ten_bit_q;
        prdata_d[direction_adapter_pkg::CTRL_DTE] = dte_q;
        prdata_d[direction_adapter_pkg::CTRL_RTS_FOLLOW] = rts_follow_q;
      end else if (stat_hit) begin
        // status is read-only; writes to it are ignored
        prdata_d[direction_adapter_pkg::STAT_TRANSMIT] =
          (dir_q == direction_adapter_pkg::transmit_phase);
        prdata_d[direction_adapter_pkg::STAT_RTS] = rts_o;
        prdata_d[direction_adapter_pkg::STAT_RS232_IN] = src_level;
        prdata_d[direction_adapter_pkg::STAT_RS485_IN] = line_sync_q[1];
        prdata_d[direction_adapter_pkg::STAT_REFUSED] = refused_q;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= pready_d;
      pslverr <= pslverr_d;
      prdata <= prdata_d;
    end
  end

endmodule : half_duplex_direction_adapter
`default_nettype wire

// ---- hdl/direction_adapter_pkg.sv ----
// constants for the half-duplex direction adapter
// What this block does
// - while bytes move from the rs-232 side to the rs-485 side the adapter drives the rs-485 line.
// - when idle or passing rs-485 data to the rs-232 side the rs-485 driver is released.
// - activity on the rs-232 transmit input switches to transmit direction at once.
// - receive direction returns only after the input has stayed idle for the turnaround time.
// - turnaround is 0.5, 1.0, 2.0, 4.0, 7.0 or 14.0 ms for 38.4k-115.2k, 19.2k, 9.6k, 4.8k, 2.4k, 1.2k.
// - the 3-bit baud selector codes 000 to 101 pick those rates, a raised switch reading one.
// - only rates from 1200 baud to 115.2 kbaud are accepted, codes 110 and 111 are refused.
// - the framing bit selects 10-bit characters when one and 11-bit characters when zero.
// - the orientation bit selects dte when one and dce when zero.
// - with rts following set, rts is asserted while the adapter is in receive direction, idle included, else deasserted.
// - with rts following clear, rts is held asserted whatever the direction.
// - rts is driven only in dte orientation, and the rts mode has no effect in dce.
// - in dte the adapter reads pin 2 and drives pin 3, in dce these two are swapped.
`default_nettype none
package direction_adapter_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CNT_W = 20;

  // turnaround times in ms per baud class
  localparam real TA_115K_MS = 0.5;
  localparam real TA_19K_MS = 1.0;
  localparam real TA_9K6_MS = 2.0;
  localparam real TA_4K8_MS = 4.0;
  localparam real TA_2K4_MS = 7.0;
  localparam real TA_1K2_MS = 14.0;

  // least times: round up to whole clock cycles
  localparam int TA_115K_CYC = int'($ceil(TA_115K_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int TA_19K_CYC = int'($ceil(TA_19K_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int TA_9K6_CYC = int'($ceil(TA_9K6_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int TA_4K8_CYC = int'($ceil(TA_4K8_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int TA_2K4_CYC = int'($ceil(TA_2K4_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int TA_1K2_CYC = int'($ceil(TA_1K2_MS * 1.0e6 / CLK_PERIOD_NS));

  // baud selector codes
  localparam logic [2:0] BAUD_115K = 3'h0;
  localparam logic [2:0] BAUD_19K = 3'h1;
  localparam logic [2:0] BAUD_9K6 = 3'h2;
  localparam logic [2:0] BAUD_4K8 = 3'h3;
  localparam logic [2:0] BAUD_2K4 = 3'h4;
  localparam logic [2:0] BAUD_1K2 = 3'h5;

  // register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;

  // control fields
  localparam int CTRL_BAUD_LSB = 0;
  localparam int CTRL_TEN_BIT = 3;
  localparam int CTRL_DTE = 4;
  localparam int CTRL_RTS_FOLLOW = 5;
  localparam logic [2:0] CTRL_BAUD_RST = 3'h0;
  localparam logic CTRL_TEN_BIT_RST = 1'b0;
  localparam logic CTRL_DTE_RST = 1'b0;
  localparam logic CTRL_RTS_FOLLOW_RST = 1'b1;

  // status fields
  localparam int STAT_TRANSMIT = 0;
  localparam int STAT_RTS = 1;
  localparam int STAT_RS232_IN = 2;
  localparam int STAT_RS485_IN = 3;
  localparam int STAT_REFUSED = 4;

  typedef enum logic {
    receive_phase,
    transmit_phase
  } direction_t;
endpackage : direction_adapter_pkg
`default_nettype wire

// ---- verification/half_duplex_direction_adapter_props.sv ----
// assertion checker for the half-duplex direction adapter
`default_nettype none
module half_duplex_direction_adapter_props #(
  parameter int TA_115K_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin2_i,
  input wire logic pin2_o,
  input wire logic pin2_oe,
  input wire logic pin3_i,
  input wire logic pin3_o,
  input wire logic pin3_oe,
  input wire logic rts_o,
  input wire logic rts_oe,
  input wire logic line_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic tx_in;
  int idle_d;
  int idle_q;
  assign tx_in = pin2_oe ? pin3_i : pin2_i;
  // cycles the rs-232 transmit input has stayed high
  always_comb idle_d = tx_in ? idle_q + 1 : 0;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) idle_q <= 0;
    else idle_q <= idle_d;
  end
  sequence s_act; $fell(tx_in); endsequence
  sequence s_drive; ##[1:4] line_oe; endsequence
  property p_fast; s_act |-> s_drive; endproperty
  property p_idle; $fell(line_oe) |-> idle_q >= TA_115K_CYC; endproperty
  property p_orient; $past(rstn) |-> pin2_oe != pin3_oe; endproperty
  property p_rts_oe; $past(rstn) |-> rts_oe == pin3_oe; endproperty
  property p_rts_dce; !rts_oe |-> !rts_o; endproperty
  property p_rts_rx; rts_oe && !line_oe |-> rts_o; endproperty
  property p_block; line_oe && $past(line_oe) |-> (pin2_oe ? pin2_o : pin3_o); endproperty
  property p_ready; psel && penable && !pready |=> pready ##1 !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  a_fast: assert property (p_fast) else $error("late transmit");
  a_idle: assert property (p_idle) else $error("early receive");
  a_orient: assert property (p_orient) else $error("pin roles");
  a_rts_oe: assert property (p_rts_oe) else $error("rts enable");
  a_rts_dce: assert property (p_rts_dce) else $error("rts in dce");
  a_rts_rx: assert property (p_rts_rx) else $error("rts in receive");
  a_block: assert property (p_block) else $error("rx leak");
  a_ready: assert property (p_ready) else $error("pready timing");
  a_err: assert property (p_err) else $error("lone pslverr");
endmodule : half_duplex_direction_adapter_props
bind half_duplex_direction_adapter half_duplex_direction_adapter_props #(
  .TA_115K_CYC(TA_115K_CYC)
) u_half_duplex_direction_adapter_props (.core_clk, .rstn, .psel, .penable, .pready,
  .pslverr, .pin2_i, .pin2_o, .pin2_oe, .pin3_i, .pin3_o, .pin3_oe, .rts_o, .rts_oe,
  .line_oe);
`default_nettype wire

// ---- verification/rs_far_end.sv ----
// far-end model: rs-232 device and rs-485 controller
`default_nettype none
module rs_far_end (
  input wire logic core_clk,
  input wire logic dte,
  input wire logic line_oe,
  input wire logic line_o,
  output logic pin2_i,
  output logic pin3_i,
  output logic line_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic dev_q = 1'b1;
  logic ctl_q = 1'b1;
  // device sends on pin 2 in dte, on pin 3 in dce; other pin rests at mark
  assign pin2_i = dte ? dev_q : 1'b1;
  assign pin3_i = dte ? 1'b1 : dev_q;
  // biased bus: adapter when enabled, else the controller
  assign line_i = line_oe ? line_o : ctl_q;
  task automatic dev_low(input int n);
    dev_q <= 1'b0;
    repeat (n) @(posedge core_clk);
    dev_q <= 1'b1;
  endtask : dev_low
  task automatic ctl_low(input int gap, input int n);
    // callers start the gap once the adapter has let go of the line
    repeat (gap) @(posedge core_clk);
    ctl_q <= 1'b0;
    repeat (n) @(posedge core_clk);
    ctl_q <= 1'b1;
  endtask : ctl_low
endmodule : rs_far_end
`default_nettype wire

// ---- verification/half_duplex_direction_adapter_test.sv ----
// self-checking bench for the half-duplex direction adapter
`default_nettype none
module half_duplex_direction_adapter_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ta_cyc [6] = '{20, 40, 80, 160, 280, 560};
  localparam logic [11:0] ctrl_a = direction_adapter_pkg::CTRL_OFFSET;
  localparam logic [11:0] stat_a = direction_adapter_pkg::STATUS_OFFSET;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, dte;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pin2_i, pin2_o, pin2_oe, pin3_i, pin3_o, pin3_oe;
  logic rts_o, rts_oe, line_i, line_o, line_oe, ten_bit_frame;
  int err_count, check_count, n;
  half_duplex_direction_adapter #(.TA_115K_CYC(ta_cyc[0]), .TA_19K_CYC(ta_cyc[1]),
    .TA_9K6_CYC(ta_cyc[2]), .TA_4K8_CYC(ta_cyc[3]), .TA_2K4_CYC(ta_cyc[4]),
    .TA_1K2_CYC(ta_cyc[5])) u_half_duplex_direction_adapter (.core_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin2_i, .pin2_o,
    .pin2_oe, .pin3_i, .pin3_o, .pin3_oe, .rts_o, .rts_oe, .line_i, .line_o, .line_oe,
    .ten_bit_frame);
  rs_far_end u_rs_far_end (.core_clk, .dte, .line_oe, .line_o, .pin2_i, .pin3_i, .line_i);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic eexp);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      err_count++;
      $display("wrong value at %0t: no pready", $time);
      report_and_stop();
    end
    if (!wr) check(prdata, exp);
    check(32'(pslverr), 32'(eexp));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wait_oe(input logic lvl, input int lim);
    for (n = 0; n < lim && line_oe !== lvl; n++) @(posedge core_clk);
    if (n == lim) begin
      err_count++;
      $display("wrong value at %0t: line enable stuck", $time);
      report_and_stop();
    end
  endtask : wait_oe
  function automatic logic [31:0] pins();
    return 32'({pin2_oe, pin3_oe, rts_oe, rts_o, ten_bit_frame});
  endfunction : pins
  initial begin
    {rstn, psel, penable, pwrite, dte} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge core_clk);
    check(pins(), 32'h10);
    check(32'(direction_adapter_pkg::TA_115K_CYC), 32'h61a8);
    check(32'(direction_adapter_pkg::TA_19K_CYC), 32'hc350);
    check(32'(direction_adapter_pkg::TA_9K6_CYC), 32'h186a0);
    check(32'(direction_adapter_pkg::TA_4K8_CYC), 32'h30d40);
    check(32'(direction_adapter_pkg::TA_2K4_CYC), 32'h55730);
    check(32'(direction_adapter_pkg::TA_1K2_CYC), 32'haae60);
    apb(1'b0, ctrl_a, 32'h0, 32'h20, 1'b0);
    apb(1'b0, stat_a, 32'h0, 32'hc, 1'b0);
    apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b1);
    for (int b = 0; b < 6; b++) begin
      apb(1'b1, ctrl_a, 32'(b), 32'h0, 1'b0);
      u_rs_far_end.dev_low(3);
      wait_oe(1'b1, 4);
      check(32'({line_oe, line_o}), 32'h2);
      repeat (ta_cyc[b] / 2) @(posedge core_clk);
      check(32'(line_oe), 32'h1);
      u_rs_far_end.dev_low(2);
      wait_oe(1'b0, ta_cyc[b] + 20);
      check(32'(n >= ta_cyc[b] && n <= ta_cyc[b] + 8), 32'h1);
      u_rs_far_end.ctl_low(ta_cyc[b], 6);
      check(32'({pin2_oe, pin2_o}), 32'h2);
    end
    apb(1'b1, ctrl_a, 32'h6, 32'h0, 1'b0);
    apb(1'b0, ctrl_a, 32'h0, 32'h5, 1'b0);
    apb(1'b0, stat_a, 32'h0, 32'h1c, 1'b0);
    apb(1'b1, ctrl_a, 32'h38, 32'h0, 1'b0);
    dte <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(pins(), 32'hf);
    apb(1'b0, stat_a, 32'h0, 32'he, 1'b0);
    u_rs_far_end.dev_low(3);
    wait_oe(1'b1, 4);
    check(32'(rts_o), 32'h0);
    wait_oe(1'b0, 60);
    apb(1'b1, ctrl_a, 32'h18, 32'h0, 1'b0);
    u_rs_far_end.dev_low(3);
    wait_oe(1'b1, 4);
    check(32'(rts_o), 32'h1);
    wait_oe(1'b0, 60);
    u_rs_far_end.ctl_low(ta_cyc[0], 6);
    check(32'({pin3_oe, pin3_o}), 32'h2);
    report_and_stop();
  end
endmodule : half_duplex_direction_adapter_test
`default_nettype wire
